/* File: dv/debug_host_model.sv */
`timescale 1ns/10ps
`default_nettype none
// ****************************************************************
// Host adapter model: drives the link clock and the data line
// ****************************************************************
module debug_host_model (
	input  wire logic i_clk,
	input  wire logic i_line,
	output logic      o_clk,
	output logic      o_oe,
	output logic      o_val
);
	import debug_select_pkg::*;

	// Clock idles low between frames, so no stray edges reach the device
	initial begin
		o_clk = 1'b0;
		o_oe  = 1'b1;
		o_val = 1'b0;
	end

	// One frame: two instruction bits then eight data bits, LSB first
	task automatic xfer(input logic [1:0] ins, input logic [7:0] wd, output logic [7:0] rd);
		logic [9:0] bits;
		logic       rdf;
		bits = {wd, ins};
		rdf  = !ins[0];
		rd   = 8'h00;
		// Start just after a device clock edge so no link edge lands on one
		@(posedge i_clk);
		#1;
		for (int i = 0; i < 10; i++) begin
			#31.25;
			if (o_oe) o_val = bits[i];
			#31.25;
			o_clk = 1'b1;
			if (rdf && i >= 2) rd[i-2] = i_line;
			// Let go before the turnaround fall, or both ends fight
			if (rdf && i == 1) o_oe = 1'b0;
			#62.5;
			o_clk = 1'b0;
		end
		#125;
		o_oe = 1'b1;
	endtask

	// Cut frame: n clock pulses with the line high, then the clock is left low
	task automatic cut(input int n);
		@(posedge i_clk);
		#1;
		for (int i = 0; i < n; i++) begin
			#31.25;
			o_val = 1'b1;
			#31.25;
			o_clk = 1'b1;
			#62.5;
			o_clk = 1'b0;
		end
	endtask
endmodule
`default_nettype wire

/* File: dv/tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin fail_count++; $display("[FAIL] t=%0t got %h exp %h", $time, got, exp); end end
// ****************************************************************
// Bench top: host model, device and checks
// ****************************************************************
module tb_top;
	import debug_select_pkg::*;
	localparam logic [7:0] DEV_ID = 8'h3c; // Arbitrary value
	localparam logic [7:0] REV_ID = 8'h07; // Arbitrary value
	logic        i_clk     = 1'b0;
	logic        i_reset_n = 1'b0;
	logic        h_clk;
	logic        h_oe;
	logic        h_val;
	logic        d_data;
	logic        d_oe;
	logic        line;
	logic [7:0]  target;
	logic [7:0]  rd;
	logic [7:0]  v;
	logic [7:0]  exp_v;
	flash_port_t flash;
	int          fail_count = 0;
	int          n_checks   = 0;
	int          wr_pulses  = 0;
	logic [7:0]  codes [5]  = '{ADDR_DEVICE_ID, ADDR_REVISION, ADDR_FLASH_CTL, ADDR_FLASH_DATA, 8'h03};

	// Released line shows the inverse of the host's last value, not a lucky copy
	assign line = d_oe ? d_data : (h_oe ? h_val : ~h_val);

	always #5 i_clk = ~i_clk;

	debug_host_model u_host (
		.i_clk  (i_clk),
		.i_line (line),
		.o_clk  (h_clk),
		.o_oe   (h_oe),
		.o_val  (h_val)
	);

	two_wire_debug_register_select #(.DEVICE_ID(DEV_ID), .REVISION_ID(REV_ID)) uut (
		.i_clk                 (i_clk),
		.i_reset_n             (i_reset_n),
		.i_debug_link_clock    (h_clk),
		.i_debug_link_data     (line),
		.o_debug_link_data     (d_data),
		.o_debug_link_data_oe  (d_oe),
		.o_debug_target_select (target),
		.o_flash               (flash)
	);

	// Count write strobes and catch both ends driving at once
	always @(posedge i_clk) begin
		wr_pulses <= wr_pulses + int'(flash.ctl_wr) + int'(flash.data_wr);
		// Outputs are unknown until the first reset edge lands
		if (i_reset_n) `CHK(d_oe & h_oe, 1'b0)
	end

	task automatic complete_run();
		$display("checks=%0d failures=%0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// Watchdog: a hang counts as a failure
	initial begin
		#200000;
		fail_count++;
		complete_run();
	end

	// Every target code: select, read back, write, read
	initial begin
		repeat (6) @(posedge i_clk);
		#1 i_reset_n = 1'b1;
		repeat (8) @(posedge i_clk);
		`CHK(target, TARGET_SELECT_RESET)
		`CHK(flash.ctl, FLASH_CTL_RESET)
		`CHK(flash.data, FLASH_DATA_RESET)
		foreach (codes[k]) begin
			v = {codes[k][3:0], ~codes[k][3:0]};
			case (codes[k])
				ADDR_DEVICE_ID:                  exp_v = DEV_ID;
				ADDR_REVISION:                   exp_v = REV_ID;
				ADDR_FLASH_CTL, ADDR_FLASH_DATA: exp_v = v;
				default:                         exp_v = UNMAPPED_READ;
			endcase
			u_host.xfer(INS_ADDR_WRITE, codes[k], rd);
			`CHK(target, codes[k])
			u_host.xfer(INS_ADDR_READ, 8'h00, rd);
			`CHK(rd, codes[k])
			u_host.xfer(INS_DATA_WRITE, v, rd);
			u_host.xfer(INS_DATA_READ, 8'h00, rd);
			`CHK(rd, exp_v)
		end
		// Only the two flash writes may strobe; identifier writes are dropped
		`CHK(wr_pulses, 2)
		`CHK(flash.ctl, 8'h2d)
		`CHK(flash.data, 8'h4b)
		// Cut frame then long clock low: frame dropped, registers kept, next frame aligned
		u_host.cut(4);
		#(LINK_RESET_NS + 1000);
		`CHK(target, codes[4])
		u_host.xfer(INS_ADDR_WRITE, ADDR_FLASH_CTL, rd);
		`CHK(target, ADDR_FLASH_CTL)
		u_host.xfer(INS_DATA_READ, 8'h00, rd);
		`CHK(rd, 8'h2d)
		complete_run();
	end
endmodule
`default_nettype wire

/* File: hw/two_wire_debug_register_select.sv */
// Overview of operation
// - Link is one host-driven clock line plus one two-way data line.
// - Debug registers are reached only through link address and data commands.
// - Eight-bit target select register, link-writable and readable, steers data commands.
// - Target code 0x00 makes data reads return the device identifier.
// - Target code 0x01 makes data reads return the revision identifier.
// - Target code 0x02 makes data reads and writes reach flash control.
// - Target code 0xb4 makes data reads and writes reach flash data.
`timescale 1ns/10ps
`default_nettype none
module two_wire_debug_register_select #(
	parameter logic [7:0] DEVICE_ID   = 8'h5a, // Arbitrary value
	parameter logic [7:0] REVISION_ID = 8'h01  // Arbitrary value
) (
	input  wire logic                         i_clk,
	input  wire logic                         i_reset_n,
	input  wire logic                         i_debug_link_clock,
	input  wire logic                         i_debug_link_data,
	output logic                              o_debug_link_data,
	output logic                              o_debug_link_data_oe,
	output logic [7:0]                        o_debug_target_select,
	output debug_select_pkg::flash_port_t     o_flash
);
	import debug_select_pkg::*;

	// ****************************************************************
	// Pin synchronisers
	// ****************************************************************
	logic [2:0]           clk_sync_r;
	logic [2:0]           dat_sync_r;
	logic                 clk_lvl_r;
	logic                 clk_lvl_nxt;
	logic                 dat_lvl_r;
	logic                 dat_lvl_nxt;
	logic                 link_rise;
	logic                 link_fall;

	// Level only moves once stages two and three agree, rejecting glitches
	always_comb begin
		clk_lvl_nxt = (clk_sync_r[1] == clk_sync_r[2]) ? clk_sync_r[2] : clk_lvl_r;
		dat_lvl_nxt = (dat_sync_r[1] == dat_sync_r[2]) ? dat_sync_r[2] : dat_lvl_r;
		link_rise   = clk_lvl_nxt & ~clk_lvl_r;
		link_fall   = ~clk_lvl_nxt & clk_lvl_r;
	end

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			clk_sync_r <= 3'h0;
			dat_sync_r <= 3'h0;
			clk_lvl_r  <= 1'b0;
			dat_lvl_r  <= 1'b0;
		end else begin
			clk_sync_r <= {clk_sync_r[1:0], i_debug_link_clock};
			dat_sync_r <= {dat_sync_r[1:0], i_debug_link_data};
			clk_lvl_r  <= clk_lvl_nxt;
			dat_lvl_r  <= dat_lvl_nxt;
		end
	end

	// ****************************************************************
	// Frame engine and registers
	// ****************************************************************
	link_state_t          state_r;
	link_state_t          state_nxt;
	logic [2:0]           bit_cnt_r;
	logic [2:0]           bit_cnt_nxt;
	logic [1:0]           instr_r;
	logic [1:0]           instr_nxt;
	logic [7:0]           shift_r;
	logic [7:0]           shift_nxt;
	logic                 oe_r;
	logic                 oe_nxt;
	logic [LOW_CNT_W-1:0] low_cnt_r;
	logic [LOW_CNT_W-1:0] low_cnt_nxt;
	logic                 link_abort;
	logic [7:0]           target_r;
	logic [7:0]           target_nxt;
	logic [7:0]           flash_ctl_r;
	logic [7:0]           flash_ctl_nxt;
	logic [7:0]           flash_data_r;
	logic [7:0]           flash_data_nxt;
	logic                 ctl_wr_r;
	logic                 ctl_wr_nxt;
	logic                 data_wr_r;
	logic                 data_wr_nxt;
	logic                 rd_load;
	logic                 wr_commit;
	logic [1:0]           full_instr;
	logic [7:0]           wr_byte;
	logic [7:0]           rd_value;

	// Read mux: the target select picks what a data read returns
	always_comb begin
		unique case (target_r)
			ADDR_DEVICE_ID:  rd_value = DEVICE_ID;
			ADDR_REVISION:   rd_value = REVISION_ID;
			ADDR_FLASH_CTL:  rd_value = flash_ctl_r;
			ADDR_FLASH_DATA: rd_value = flash_data_r;
			default:         rd_value = UNMAPPED_READ;
		endcase
	end

	// Bits are taken on link rise; read data shifts on link rise, and the driver turns on at the first link fall
	always_comb begin
		state_nxt      = state_r;
		bit_cnt_nxt    = bit_cnt_r;
		instr_nxt      = instr_r;
		shift_nxt      = shift_r;
		oe_nxt         = oe_r;
		target_nxt     = target_r;
		flash_ctl_nxt  = flash_ctl_r;
		flash_data_nxt = flash_data_r;
		ctl_wr_nxt     = 1'b0;
		data_wr_nxt    = 1'b0;
		rd_load        = 1'b0;
		wr_commit      = 1'b0;
		full_instr     = {dat_lvl_r, instr_r[0]};
		wr_byte        = {dat_lvl_r, shift_r[7:1]};
		// Long clock-low aborts a frame so a lost host can resynchronise
		link_abort     = (low_cnt_r == LOW_CNT_W'(LINK_RESET_CYC - 1));
		// Count saturates past the limit so the abort fires once, not on every idle cycle
		low_cnt_nxt    = clk_lvl_r ? '0 :
			((low_cnt_r == LOW_CNT_W'(LINK_RESET_CYC)) ? low_cnt_r : low_cnt_r + LOW_CNT_W'(1));
		if (link_abort) begin
			state_nxt   = ST_INSTR;
			bit_cnt_nxt = 3'h0;
			oe_nxt      = 1'b0;
			// A rise landing in the abort cycle is the first bit of a new frame
			if (link_rise) begin
				instr_nxt[0] = dat_lvl_r;
				bit_cnt_nxt  = 3'h1;
			end
		end else begin
			unique case (state_r)
				ST_INSTR: begin
					if (link_rise) begin
						instr_nxt[bit_cnt_r[0]] = dat_lvl_r;
						bit_cnt_nxt = bit_cnt_r + 3'h1;
						if (bit_cnt_r == 3'(INSTR_LAST_BIT)) begin
							bit_cnt_nxt = 3'h0;
							if (full_instr == INS_DATA_READ) begin
								rd_load   = 1'b1;
								shift_nxt = rd_value;
								state_nxt = ST_RDATA;
							end else if (full_instr == INS_ADDR_READ) begin
								shift_nxt = target_r;
								state_nxt = ST_RDATA;
							end else begin
								state_nxt = ST_WDATA;
							end
						end
					end
				end
				ST_WDATA: begin
					if (link_rise) begin
						shift_nxt   = wr_byte;
						bit_cnt_nxt = bit_cnt_r + 3'h1;
						if (bit_cnt_r == 3'(DATA_LAST_BIT)) begin
							wr_commit   = 1'b1;
							bit_cnt_nxt = 3'h0;
							state_nxt   = ST_INSTR;
							if (instr_r == INS_ADDR_WRITE) begin
								target_nxt = wr_byte;
							end else begin
								// Identifier targets fall through and are dropped
								unique case (target_r)
									ADDR_FLASH_CTL: begin
										flash_ctl_nxt = wr_byte;
										ctl_wr_nxt    = 1'b1;
									end
									ADDR_FLASH_DATA: begin
										flash_data_nxt = wr_byte;
										data_wr_nxt    = 1'b1;
									end
									default: begin
										flash_ctl_nxt = flash_ctl_r;
									end
								endcase
							end
						end
					end
				end
				ST_RDATA: begin
					if (link_fall) begin
						oe_nxt = 1'b1;
					end
					if (link_rise && oe_r) begin
						shift_nxt   = {1'b0, shift_r[7:1]};
						bit_cnt_nxt = bit_cnt_r + 3'h1;
						if (bit_cnt_r == 3'(DATA_LAST_BIT)) begin
							// Release the line right after the host takes bit 7
							oe_nxt      = 1'b0;
							bit_cnt_nxt = 3'h0;
							state_nxt   = ST_INSTR;
						end
					end
				end
			endcase
		end
	end

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			state_r      <= ST_INSTR;
			bit_cnt_r    <= 3'h0;
			instr_r      <= 2'h0;
			shift_r      <= 8'h00;
			oe_r         <= 1'b0;
			low_cnt_r    <= '0;
			target_r     <= TARGET_SELECT_RESET;
			flash_ctl_r  <= FLASH_CTL_RESET;
			flash_data_r <= FLASH_DATA_RESET;
			ctl_wr_r     <= 1'b0;
			data_wr_r    <= 1'b0;
		end else begin
			state_r      <= state_nxt;
			bit_cnt_r    <= bit_cnt_nxt;
			instr_r      <= instr_nxt;
			shift_r      <= shift_nxt;
			oe_r         <= oe_nxt;
			low_cnt_r    <= low_cnt_nxt;
			target_r     <= target_nxt;
			flash_ctl_r  <= flash_ctl_nxt;
			flash_data_r <= flash_data_nxt;
			ctl_wr_r     <= ctl_wr_nxt;
			data_wr_r    <= data_wr_nxt;
		end
	end

	// Outputs all come straight from flip-flops
	assign o_debug_link_data     = shift_r[0];
	assign o_debug_link_data_oe  = oe_r;
	assign o_debug_target_select = target_r;
	assign o_flash               = '{ctl: flash_ctl_r, data: flash_data_r,
		ctl_wr: ctl_wr_r, data_wr: data_wr_r};

	// ****************************************************************
	// Checks
	// ****************************************************************
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_reset_n);

	chk_oe_only_reading: assert property (oe_r |-> state_r == ST_RDATA)
		else $error("Data line driven outside a read");
	chk_abort_releases: assert property (link_abort |=> state_r == ST_INSTR && !oe_r)
		else $error("Frame not aborted by long clock low");
	chk_target_update: assert property (wr_commit && instr_r == INS_ADDR_WRITE
		|=> target_r == $past(wr_byte))
		else $error("Target select not written");
	chk_devid_read: assert property (rd_load && target_r == ADDR_DEVICE_ID
		|=> shift_r == DEVICE_ID)
		else $error("Device identifier not returned");
	chk_rev_read: assert property (rd_load && target_r == ADDR_REVISION
		|=> shift_r == REVISION_ID)
		else $error("Revision identifier not returned");
	chk_ctl_write: assert property (wr_commit && instr_r == INS_DATA_WRITE
		&& target_r == ADDR_FLASH_CTL |=> ctl_wr_r && flash_ctl_r == $past(wr_byte) ##1 !ctl_wr_r)
		else $error("Flash control write lost");
	chk_data_write: assert property (wr_commit && instr_r == INS_DATA_WRITE
		&& target_r == ADDR_FLASH_DATA |=> data_wr_r && flash_data_r == $past(wr_byte))
		else $error("Flash data write lost");
	chk_id_write_dropped: assert property (wr_commit && instr_r == INS_DATA_WRITE
		&& target_r <= ADDR_REVISION |=> !ctl_wr_r && !data_wr_r
		&& $stable(flash_ctl_r) && $stable(flash_data_r))
		else $error("Identifier write not ignored");

	cov_addr_write: cover property (wr_commit && instr_r == INS_ADDR_WRITE);
	cov_flash_read: cover property (rd_load && target_r == ADDR_FLASH_DATA);
	cov_read_done: cover property ($fell(oe_r) && state_r == ST_INSTR);
	cov_abort: cover property (link_abort && state_r != ST_INSTR);

endmodule
`default_nettype wire

/* File: shared/debug_select_pkg.sv */
`default_nettype none
package debug_select_pkg;

	// ****************************************************************
	// Timing
	// ****************************************************************
	localparam int CLK_PERIOD_NS  = 10;
	// Clock held low this long aborts any frame in progress
	localparam int LINK_RESET_NS  = 20000;
	localparam int LINK_RESET_CYC = (LINK_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int LOW_CNT_W      = 12;

	// ****************************************************************
	// Target codes held in debug_target_select
	// ****************************************************************
	localparam logic [7:0] ADDR_DEVICE_ID  = 8'h00;
	localparam logic [7:0] ADDR_REVISION   = 8'h01;
	localparam logic [7:0] ADDR_FLASH_CTL  = 8'h02;
	localparam logic [7:0] ADDR_FLASH_DATA = 8'hb4;

	// ****************************************************************
	// Reset values and the unmapped read value
	// ****************************************************************
	localparam logic [7:0] TARGET_SELECT_RESET = 8'h00;
	localparam logic [7:0] FLASH_CTL_RESET     = 8'h00;
	localparam logic [7:0] FLASH_DATA_RESET    = 8'h00;
	localparam logic [7:0] UNMAPPED_READ       = 8'h00;

	// ****************************************************************
	// Frame fields: two instruction bits then eight data bits, LSB first
	// ****************************************************************
	localparam int         INSTR_LAST_BIT = 1;
	localparam int         DATA_LAST_BIT  = 7;
	localparam logic [1:0] INS_DATA_READ  = 2'h0;
	localparam logic [1:0] INS_DATA_WRITE = 2'h1;
	localparam logic [1:0] INS_ADDR_READ  = 2'h2;
	localparam logic [1:0] INS_ADDR_WRITE = 2'h3;

	typedef enum logic [1:0] {
		ST_INSTR,
		ST_WDATA,
		ST_RDATA
	} link_state_t;

	// Flash programming registers as seen by the flash controller
	typedef struct packed {
		logic [7:0] ctl;
		logic [7:0] data;
		logic       ctl_wr;
		logic       data_wr;
	} flash_port_t;

endpackage
`default_nettype wire
